// ==== rtl/pcm_pkg.sv ====
// shared constants for the program counter, stack and indirect pointer block
package pcm_pkg;
   // ==========================================================
   // widths and sizes
   localparam int PC_W        = 15;
   localparam int PM_WORDS    = 4096;
   localparam int PM_AW       = 12;
   localparam int PM_DW       = 14;
   localparam int STK_DEPTH   = 16;
   localparam int STK_PW      = 5;
   localparam int PTR_W       = 16;
   localparam int PTR_PM_BIT  = 15;
   localparam int NUM_INSN    = 48;
   localparam int INSN_IW     = 6;
   localparam int CTX_W       = 32;

   // ==========================================================
   // vectors
   localparam logic [14:0] RESET_VECTOR = 15'h0000;
   localparam logic [14:0] INT_VECTOR   = 15'h0004;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] CTRL_OFS  = 8'h00;
   localparam logic [7:0] PCON_OFS  = 8'h04;
   localparam logic [7:0] MASK_OFS  = 8'h08;
   localparam logic [7:0] PTR0_OFS  = 8'h0c;
   localparam logic [7:0] PTR1_OFS  = 8'h10;
   localparam logic [7:0] STATE_OFS = 8'h14;

   // ==========================================================
   // field positions and reset values
   localparam int CTRL_FAULT_RST_BIT = 0;
   localparam int CTRL_MASTER_CLEAR_PIN_CFG_BIT  = 1;
   localparam int PCON_OVF_BIT       = 0;
   localparam int PCON_UNF_BIT       = 1;
   localparam int STATE_SP_LSB       = 16;
   localparam logic [1:0]  CTRL_RESET = 2'h2;
   localparam logic [1:0]  MASK_RESET = 2'h0;
   localparam logic [15:0] PTR_RESET  = 16'h0000;

   // ==========================================================
   // indirect access sequencer
   typedef enum logic [1:0] {IND_IDLE, IND_PM_FETCH, IND_DONE} pcm_ind_e;
endpackage : pcm_pkg

// ==== rtl/pcm_stack_if.sv ====
// carrier between the address block and its return-address stack
interface pcm_stack_if;
   import pcm_pkg::*;
   logic               clear;
   logic               push;
   logic               pop;
   logic [PC_W-1:0]    push_addr;
   logic [PC_W-1:0]    top_addr;
   logic [STK_PW-1:0]  depth;
   logic               overflow;
   logic               underflow;

   modport owner (output clear, push, pop, push_addr,
                  input  top_addr, depth, overflow, underflow);
   modport stack (input  clear, push, pop, push_addr,
                  output top_addr, depth, overflow, underflow);
endinterface : pcm_stack_if

// ==== rtl/pcm_stack.sv ====
// sixteen-entry return-address stack with fault detection
module pcm_stack
   import pcm_pkg::*;
#(
   parameter int DEPTH = STK_DEPTH
) (
   // clock and reset
   input wire logic  clk,
   input wire logic  rst,
   // owner side
   pcm_stack_if.stack st
);
   // ==========================================================
   // storage
   logic [PC_W-1:0]   mem_q [DEPTH];
   logic [STK_PW-1:0] sp_q;
   logic              full;
   logic              empty;

   assign full  = (sp_q == STK_PW'(DEPTH));
   assign empty = (sp_q == '0);
   assign st.depth     = sp_q;
   assign st.top_addr  = empty ? '0 : mem_q[sp_q[3:0] - 4'h1];
   // a push on a full stack is dropped rather than wrapping over the oldest entry
   assign st.overflow  = st.push & full;
   assign st.underflow = st.pop & empty;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sp_q <= '0;
      end else if (st.clear) begin
         sp_q <= '0;
      end else if (st.push && !full) begin
         sp_q <= sp_q + 5'h1;
      end else if (st.pop && !empty) begin
         sp_q <= sp_q - 5'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (st.push && !full) begin
         mem_q[sp_q[3:0]] <= st.push_addr;
      end
   end
endmodule : pcm_stack

// ==== rtl/pcm_core_addr.sv ====
// program counter, return stack, indirect pointers and context shadows of the cpu core
//
// Notes on behaviour
// - the master clear pin resets the device when its function bit is 1 and is a plain input when 0.
// - a return stack of 16 entries of 15 bits serves calls, returns and interrupts.
// - stack overflow or underflow sets its flag in the power control status register and, if enabled, issues a software reset.
// - two 16-bit indirect pointers reach data memory and program memory through one pointer space.
// - an indirect read of program memory takes one extra cycle to fetch the word.
// - the program counter is 15 bits, a space of 32K words of 14 bits.
// - program memory holds 4096 words ending at 0FFFh and higher addresses wrap into it.
// - execution starts at 0000h after reset and interrupt entry branches to 0004h.
// - with bit 7 of a pointer's high byte set, indirect reads come from program memory.
// - a move-indirect-to-working read of program memory returns the low eight bits of the word.
// - indirect writes aimed at program memory have no effect.
// - interrupt entry copies core context into shadows and return from interrupt restores it.
// - the decoder accepts exactly 48 instructions and flags any other index.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
module pcm_core_addr
   import pcm_pkg::*;
#(
   parameter int PM_SIZE = PM_WORDS
) (
   // clock and reset
   input  wire logic                      CLK,
   input  wire logic                      RESET,
   // apb slave
   input  wire logic                      PSEL,
   input  wire logic                      PENABLE,
   input  wire logic                      PWRITE,
   input  wire logic [7:0]                PADDR,
   input  wire logic [31:0]               PWDATA,
   output logic      [31:0]               PRDATA,
   output logic                           PREADY,
   output logic                           PSLVERR,
   // master clear pin
   input  wire logic                      MASTER_CLEAR_PIN,
   output logic                           MASTER_CLEAR_PIN_DIGITAL_IN,
   output logic                           DEVICE_RESET,
   // program flow requests
   input  wire logic                      OP_STEP,
   input  wire logic                      OP_GOTO,
   input  wire logic                      OP_CALL,
   input  wire logic                      OP_RETURN,
   input  wire logic                      OP_RETFIE,
   input  wire logic                      INT_ENTRY,
   input  wire logic [pcm_pkg::PC_W-1:0]  TARGET,
   output logic      [pcm_pkg::PC_W-1:0]  PC,
   // program memory port
   output logic      [pcm_pkg::PM_AW-1:0] PM_ADDR,
   input  wire logic [pcm_pkg::PM_DW-1:0] PM_DATA,
   // indirect access
   input  wire logic                      IND_REQ,
   input  wire logic                      IND_SEL,
   input  wire logic                      IND_WRITE,
   input  wire logic [7:0]                IND_WDATA,
   output logic                           IND_BUSY,
   output logic                           IND_ACK,
   output logic      [7:0]                IND_RDATA,
   // data memory port
   output logic      [pcm_pkg::PTR_W-1:0] DM_ADDR,
   output logic                           DM_WE,
   output logic      [7:0]                DM_WDATA,
   input  wire logic [7:0]                DM_RDATA,
   // context shadowing
   input  wire logic [pcm_pkg::CTX_W-1:0] CTX_IN,
   output logic      [pcm_pkg::CTX_W-1:0] CTX_OUT,
   output logic                           CTX_RESTORE,
   // instruction decode check
   input  wire logic [pcm_pkg::INSN_IW-1:0] INSN_IDX,
   output logic                           INSN_ILLEGAL,
   // interrupt
   output logic                           IRQ
);
   import pcm_pkg::*;

   // ==========================================================
   // declarations
   logic              master_clear_pin_s1_q, master_clear_pin_s2_q;
   logic [1:0]        ctrl_q;
   logic [1:0]        pcon_q, pcon_d;
   logic [1:0]        mask_q;
   logic [PTR_W-1:0]  ptr0_q, ptr1_q;
   logic [PTR_W-1:0]  sh_ptr0_q, sh_ptr1_q;
   logic [PC_W-1:0]   pc_q, pc_d;
   logic              swrst_q;
   logic              core_rst;
   logic              master_clear_pin_rst;
   pcm_ind_e          ind_q, ind_d;
   logic [PTR_W-1:0]  ind_ptr_q;
   logic [7:0]        ind_rdata_q;
   logic              ind_ack_q;
   logic [CTX_W-1:0]  ctx_sh_q;
   logic              ctx_restore_q;
   logic [31:0]       prdata_q;

   // ==========================================================
   // master clear pin and device reset
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         master_clear_pin_s1_q <= 1'b1;
         master_clear_pin_s2_q <= 1'b1;
      end else begin
         master_clear_pin_s1_q <= MASTER_CLEAR_PIN;
         master_clear_pin_s2_q <= master_clear_pin_s1_q;
      end
   end

   // the pin is visible as an input only while not configured to reset; it only resets while configured to
   assign master_clear_pin_rst        = ctrl_q[CTRL_MASTER_CLEAR_PIN_CFG_BIT] & ~master_clear_pin_s2_q;
   assign MASTER_CLEAR_PIN_DIGITAL_IN = ~ctrl_q[CTRL_MASTER_CLEAR_PIN_CFG_BIT] & master_clear_pin_s2_q;
   assign core_rst        = master_clear_pin_rst | swrst_q;
   assign DEVICE_RESET    = core_rst;

   // ==========================================================
   // return stack
   pcm_stack_if stk ();

   pcm_stack #(
      .DEPTH (STK_DEPTH)
   ) u_stack (
      .clk (CLK),
      .rst (RESET),
      .st  (stk.stack)
   );

   logic do_int, do_retfie, do_ret, do_call, do_goto, do_step;

   // one flow request is honoured per cycle, interrupt entry first
   assign do_int    = INT_ENTRY;
   assign do_retfie = ~do_int & OP_RETFIE;
   assign do_ret    = ~do_int & ~OP_RETFIE & OP_RETURN;
   assign do_call   = ~do_int & ~OP_RETFIE & ~OP_RETURN & OP_CALL;
   assign do_goto   = ~do_int & ~OP_RETFIE & ~OP_RETURN & ~OP_CALL & OP_GOTO;
   assign do_step   = ~do_int & ~OP_RETFIE & ~OP_RETURN & ~OP_CALL & ~OP_GOTO & OP_STEP;

   assign stk.clear     = core_rst;
   assign stk.push      = ~core_rst & (do_int | do_call);
   assign stk.pop       = ~core_rst & (do_ret | do_retfie);
   // an interrupt returns to the instruction it pre-empted, a call to the next one
   assign stk.push_addr = do_int ? pc_q : pc_q + 15'h1;

   // ==========================================================
   // program counter
   always_comb begin
      pc_d = pc_q;
      if (do_int) begin
         pc_d = INT_VECTOR;
      end else if (do_retfie || do_ret) begin
         pc_d = stk.top_addr;
      end else if (do_call || do_goto) begin
         pc_d = TARGET;
      end else if (do_step) begin
         pc_d = pc_q + 15'h1;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         pc_q <= RESET_VECTOR;
      end else if (core_rst) begin
         pc_q <= RESET_VECTOR;
      end else begin
         pc_q <= pc_d;
      end
   end

   assign PC = pc_q;

   // ==========================================================
   // indirect access sequencer
   logic [PTR_W-1:0] sel_ptr;
   logic             sel_pm;
   logic             ind_start;

   assign sel_ptr   = IND_SEL ? ptr1_q : ptr0_q;
   assign sel_pm    = sel_ptr[PTR_PM_BIT];
   assign ind_start = (ind_q == IND_IDLE) & IND_REQ & ~core_rst;

   always_comb begin
      ind_d = ind_q;
      case (ind_q)
         IND_IDLE: begin
            // program memory reads need an extra cycle; writes there are dropped at once
            if (ind_start) begin
               ind_d = (sel_pm && !IND_WRITE) ? IND_PM_FETCH : IND_DONE;
            end
         end
         IND_PM_FETCH: begin
            ind_d = IND_DONE;
         end
         IND_DONE: begin
            ind_d = IND_IDLE;
         end
         default: begin
            ind_d = IND_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ind_q       <= IND_IDLE;
         ind_ptr_q   <= PTR_RESET;
         ind_rdata_q <= 8'h00;
         ind_ack_q   <= 1'b0;
      end else begin
         ind_q     <= ind_d;
         ind_ack_q <= (ind_q != IND_IDLE) & (ind_d == IND_IDLE);
         if (ind_start) begin
            ind_ptr_q <= sel_ptr;
            // writes leave the last read byte standing
            if (!sel_pm && !IND_WRITE) begin
               ind_rdata_q <= DM_RDATA;
            end
         end
         if (ind_q == IND_PM_FETCH) begin
            ind_rdata_q <= PM_DATA[7:0];
         end
      end
   end

   // data memory sees the selected pointer of either space; program space is never written
   assign DM_ADDR  = sel_ptr;
   assign DM_WE    = ind_start & IND_WRITE & ~sel_pm;
   assign DM_WDATA = IND_WDATA;
   assign IND_BUSY = (ind_q != IND_IDLE);
   assign IND_ACK  = ind_ack_q;
   assign IND_RDATA = ind_rdata_q;

   // upper address bits are ignored so any address folds into the 4K words
   logic [PM_AW-1:0] pm_fetch_addr;
   assign pm_fetch_addr = ind_ptr_q[PM_AW-1:0];
   assign PM_ADDR = (ind_q == IND_PM_FETCH) ? pm_fetch_addr : pc_q[PM_AW-1:0];

   // ==========================================================
   // context shadows
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ctx_sh_q      <= '0;
         sh_ptr0_q     <= PTR_RESET;
         sh_ptr1_q     <= PTR_RESET;
         ctx_restore_q <= 1'b0;
      end else begin
         ctx_restore_q <= do_retfie & ~core_rst;
         if (do_int && !core_rst) begin
            ctx_sh_q  <= CTX_IN;
            sh_ptr0_q <= ptr0_q;
            sh_ptr1_q <= ptr1_q;
         end
      end
   end

   assign CTX_OUT     = ctx_sh_q;
   assign CTX_RESTORE = ctx_restore_q;

   // ==========================================================
   // instruction decode check
   assign INSN_ILLEGAL = (INSN_IDX >= INSN_IW'(NUM_INSN));

   // ==========================================================
   // apb decode
   logic apb_setup, apb_wr;
   logic hit_ctrl, hit_pcon, hit_mask, hit_ptr0, hit_ptr1, hit_state, hit_any;
   logic [31:0] rd_mux;

   assign apb_setup = PSEL & ~PENABLE;
   assign apb_wr    = PSEL & PENABLE & PWRITE;
   assign hit_ctrl  = (PADDR == CTRL_OFS);
   assign hit_pcon  = (PADDR == PCON_OFS);
   assign hit_mask  = (PADDR == MASK_OFS);
   assign hit_ptr0  = (PADDR == PTR0_OFS);
   assign hit_ptr1  = (PADDR == PTR1_OFS);
   assign hit_state = (PADDR == STATE_OFS);
   assign hit_any   = hit_ctrl | hit_pcon | hit_mask | hit_ptr0 | hit_ptr1 | hit_state;

   assign rd_mux = hit_ctrl  ? {30'h0, ctrl_q} :
                   hit_pcon  ? {30'h0, pcon_q} :
                   hit_mask  ? {30'h0, mask_q} :
                   hit_ptr0  ? {16'h0, ptr0_q} :
                   hit_ptr1  ? {16'h0, ptr1_q} :
                   hit_state ? {11'h0, stk.depth, 1'b0, pc_q} : 32'h0;

   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~hit_any;
   assign PRDATA  = prdata_q;

   // ==========================================================
   // registers
   // a fault flag set in the same cycle as its write-one-to-clear stays set
   always_comb begin
      pcon_d = pcon_q;
      if (apb_wr && hit_pcon) begin
         pcon_d = pcon_q & ~PWDATA[1:0];
      end
      if (stk.overflow) begin
         pcon_d[PCON_OVF_BIT] = 1'b1;
      end
      if (stk.underflow) begin
         pcon_d[PCON_UNF_BIT] = 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ctrl_q   <= CTRL_RESET;
         pcon_q   <= 2'h0;
         mask_q   <= MASK_RESET;
         prdata_q <= 32'h0;
         swrst_q  <= 1'b0;
      end else begin
         pcon_q  <= pcon_d;
         swrst_q <= (stk.overflow | stk.underflow) & ctrl_q[CTRL_FAULT_RST_BIT];
         if (apb_setup) begin
            prdata_q <= rd_mux;
         end
         if (apb_wr && hit_ctrl) begin
            ctrl_q <= PWDATA[1:0];
         end
         if (apb_wr && hit_mask) begin
            mask_q <= PWDATA[1:0];
         end
      end
   end

   // pointers: software writes, shadow restore on return from interrupt
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ptr0_q <= PTR_RESET;
         ptr1_q <= PTR_RESET;
      end else if (do_retfie && !core_rst) begin
         ptr0_q <= sh_ptr0_q;
         ptr1_q <= sh_ptr1_q;
      end else begin
         if (apb_wr && hit_ptr0) begin
            ptr0_q <= PWDATA[15:0];
         end
         if (apb_wr && hit_ptr1) begin
            ptr1_q <= PWDATA[15:0];
         end
      end
   end

   assign IRQ = |(pcon_q & mask_q);
endmodule : pcm_core_addr

// ==== verif/pcm_core_addr_checker.sv ====
// concurrent checks on the ports of the core address block
// ==========================================================
// checker
module pcm_core_addr_checker
   import pcm_pkg::*;
(
   // clock and reset
   input wire logic                        CLK,
   input wire logic                        RESET,
   // program flow
   input wire logic                        OP_CALL,
   input wire logic                        OP_RETURN,
   input wire logic                        OP_RETFIE,
   input wire logic                        INT_ENTRY,
   input wire logic [pcm_pkg::PC_W-1:0]    TARGET,
   input wire logic [pcm_pkg::PC_W-1:0]    PC,
   input wire logic                        DEVICE_RESET,
   input wire logic                        CTX_RESTORE,
   // indirect access
   input wire logic                        IND_REQ,
   input wire logic                        IND_WRITE,
   input wire logic                        IND_BUSY,
   input wire logic                        IND_ACK,
   input wire logic [7:0]                  IND_RDATA,
   input wire logic [pcm_pkg::PTR_W-1:0]   DM_ADDR,
   input wire logic                        DM_WE,
   input wire logic [pcm_pkg::PM_AW-1:0]   PM_ADDR,
   input wire logic [pcm_pkg::PM_DW-1:0]   PM_DATA,
   // decode
   input wire logic [pcm_pkg::INSN_IW-1:0] INSN_IDX,
   input wire logic                        INSN_ILLEGAL
);
   timeunit 1ns;
   timeprecision 1ps;
   // requests made while the core is held in reset are not taken
   wire start = IND_REQ && !IND_BUSY && !DEVICE_RESET;
   wire pm_rd = start && !IND_WRITE && DM_ADDR[PTR_PM_BIT];
   wire call_only = OP_CALL && !OP_RETURN && !OP_RETFIE && !INT_ENTRY && !DEVICE_RESET;

   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);

   chk_int_vector: assert property (
      INT_ENTRY && !DEVICE_RESET |=> PC == INT_VECTOR) else $error("pc missed vector");
   chk_call_target: assert property (
      call_only |=> PC == $past(TARGET)) else $error("call target lost");
   chk_reset_pc: assert property (
      DEVICE_RESET |=> PC == RESET_VECTOR) else $error("pc not cleared");
   chk_pm_extra: assert property (
      pm_rd |=> IND_BUSY [*2] ##1 (IND_ACK && !IND_BUSY)) else $error("pm read timing");
   chk_data_ack: assert property (
      start && !pm_rd |=> (IND_BUSY && !IND_ACK) ##1 IND_ACK) else $error("data ack timing");
   chk_pm_word: assert property (
      pm_rd |=> PM_ADDR == $past(DM_ADDR[11:0]) ##1 IND_RDATA == $past(PM_DATA[7:0]))
      else $error("pm byte wrong");
   chk_no_pm_write: assert property (
      DM_WE |-> start && IND_WRITE && !DM_ADDR[PTR_PM_BIT]) else $error("pm write seen");
   chk_restore_pulse: assert property (
      OP_RETFIE && !INT_ENTRY && !DEVICE_RESET |=> CTX_RESTORE) else $error("no restore");
   chk_insn_range: assert property (
      INSN_ILLEGAL == (INSN_IDX >= NUM_INSN)) else $error("decode range wrong");
endmodule : pcm_core_addr_checker

bind pcm_core_addr pcm_core_addr_checker u_chk (
   .CLK(CLK), .RESET(RESET), .OP_CALL(OP_CALL), .OP_RETURN(OP_RETURN),
   .OP_RETFIE(OP_RETFIE), .INT_ENTRY(INT_ENTRY), .TARGET(TARGET), .PC(PC),
   .DEVICE_RESET(DEVICE_RESET), .CTX_RESTORE(CTX_RESTORE), .IND_REQ(IND_REQ),
   .IND_WRITE(IND_WRITE), .IND_BUSY(IND_BUSY), .IND_ACK(IND_ACK), .IND_RDATA(IND_RDATA),
   .DM_ADDR(DM_ADDR), .DM_WE(DM_WE), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA),
   .INSN_IDX(INSN_IDX), .INSN_ILLEGAL(INSN_ILLEGAL)
);

// ==== verif/pcm_core_addr_tb.sv ====
// self-checking bench for the core address block
module pcm_core_addr_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pcm_pkg::*;
   // ==========================================================
   // signals and model state
   logic        clk, rst, psel, penable, pwrite, pin, ind_req, ind_sel, ind_write;
   logic        pready, slverr, master_clear_pin_in, dev_rst, busy, ack, dm_we, restore, ill, irq, e;
   logic [5:0]  ops, insn;
   logic [7:0]  paddr, ind_wd, ind_rd, dm_wd, dm_rd;
   logic [11:0] pm_addr;
   logic [13:0] pm_data;
   logic [14:0] tgt, pc;
   logic [15:0] dm_addr;
   logic [31:0] pwdata, prdata, ctx_in, ctx_out, r, p;
   int          err_count, num_checks, mpc, n, i, seed;
   int          stk[$];

   // memories answer in the same cycle; the upper address bits fold into the low byte
   assign pm_data = {pm_addr[11:6], pm_addr[7:0] ^ {2{pm_addr[11:8]}}};
   assign dm_rd = dm_addr[7:0] ^ dm_addr[15:8];

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   pcm_core_addr dut (
      .CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(slverr),
      .MASTER_CLEAR_PIN(pin), .MASTER_CLEAR_PIN_DIGITAL_IN(master_clear_pin_in), .DEVICE_RESET(dev_rst),
      .OP_STEP(ops[0]), .OP_GOTO(ops[1]), .OP_CALL(ops[2]), .OP_RETURN(ops[3]),
      .OP_RETFIE(ops[4]), .INT_ENTRY(ops[5]), .TARGET(tgt), .PC(pc),
      .PM_ADDR(pm_addr), .PM_DATA(pm_data), .IND_REQ(ind_req), .IND_SEL(ind_sel),
      .IND_WRITE(ind_write), .IND_WDATA(ind_wd), .IND_BUSY(busy), .IND_ACK(ack),
      .IND_RDATA(ind_rd), .DM_ADDR(dm_addr), .DM_WE(dm_we), .DM_WDATA(dm_wd),
      .DM_RDATA(dm_rd), .CTX_IN(ctx_in), .CTX_OUT(ctx_out), .CTX_RESTORE(restore),
      .INSN_IDX(insn), .INSN_ILLEGAL(ill), .IRQ(irq)
   );

   // ==========================================================
   // tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = slverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wait_rst();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (dev_rst !== 1'b1 && n < 6);
   endtask : wait_rst

   // k: 0 step, 1 goto, 2 call, 3 return, 4 retfie, 5 interrupt entry
   task automatic flow(input int k, input logic [14:0] t);
      ops[k] <= 1'b1;
      tgt <= t;
      @(posedge clk);
      ops <= 6'h00;
      case (k)
         0: mpc = (mpc + 1) % 32768;
         1: mpc = t;
         2: begin
            if (stk.size() < 16) stk.push_back((mpc + 1) % 32768);
            mpc = t;
         end
         5: begin
            stk.push_back(mpc);
            mpc = 4;
         end
         default: mpc = (stk.size() > 0) ? stk.pop_back() : 0;
      endcase
      @(posedge clk);
      chk("pc", pc, mpc);
      chk("ctx_restore", restore, k == 4);
   endtask : flow

   task automatic ind(input logic s, input logic w, input int cyc, input logic we);
      ind_req <= 1'b1;
      ind_sel <= s;
      ind_write <= w;
      ind_wd <= 8'($random(seed));
      @(posedge clk);
      chk("dm_we", dm_we, we);
      chk("dm_wdata", dm_wd, ind_wd);
      ind_req <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 8);
      chk("ind_cycles", n, cyc);
   endtask : ind

   // ==========================================================
   // sequence
   initial begin
      seed = 32'h234b54c0;
      {rst, pin} = 2'b11;
      {psel, penable, pwrite, ind_req, ind_sel, ind_write} = 6'h00;
      {ops, insn, paddr, ind_wd, tgt, pwdata, ctx_in} = '0;
      {err_count, num_checks, mpc} = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("pc_reset", pc, RESET_VECTOR);
      apb(1'b0, CTRL_OFS, 0);
      chk("ctrl", r, CTRL_RESET);
      apb(1'b0, 8'h40, 0);
      chk("unmapped", {e, r[30:0]}, 32'h80000000);
      $display("register test done");
      flow(1, 15'h7fff);
      flow(0, 0);
      for (i = 0; i < 17; i++) flow(2, 15'($random(seed)));
      for (i = 0; i < 17; i++) flow(3, 0);
      apb(1'b0, PCON_OFS, 0);
      chk("pcon", r, 3);
      apb(1'b1, MASK_OFS, 2);
      chk("irq_on", irq, 1);
      apb(1'b1, MASK_OFS, 0);
      chk("irq_masked", irq, 0);
      apb(1'b1, PCON_OFS, 3);
      apb(1'b1, MASK_OFS, 3);
      apb(1'b0, PCON_OFS, 0);
      chk("pcon_clear", {irq, r[30:0]}, 0);
      // overflow with fault reset armed
      apb(1'b1, CTRL_OFS, 3);
      for (i = 0; i < 16; i++) flow(2, 15'(i * 100));
      ops[2] <= 1'b1;
      @(posedge clk);
      ops <= 6'h00;
      wait_rst();
      chk("sw_reset", dev_rst, 1);
      repeat (2) @(posedge clk);
      apb(1'b0, STATE_OFS, 0);
      chk("state_fault", r, 0);
      mpc = 0;
      stk.delete();
      apb(1'b1, PCON_OFS, 3);
      apb(1'b1, CTRL_OFS, 2);
      $display("stack test done");
      pin <= 1'b0;
      wait_rst();
      chk("pin_reset", dev_rst, 1);
      pin <= 1'b1;
      apb(1'b1, CTRL_OFS, 0);
      pin <= 1'b0;
      repeat (4) @(posedge clk);
      chk("pin_low", {dev_rst, master_clear_pin_in}, 0);
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      chk("pin_high", {dev_rst, master_clear_pin_in}, 1);
      apb(1'b1, CTRL_OFS, 2);
      apb(1'b1, PTR0_OFS, 32'h1234);
      flow(1, 15'h0abc);
      ctx_in <= $random(seed);
      flow(5, 0);
      chk("ctx_saved", ctx_out, ctx_in);
      apb(1'b1, PTR0_OFS, 32'h0055);
      flow(4, 0);
      apb(1'b0, PTR0_OFS, 0);
      chk("ptr_restored", r, 32'h1234);
      $display("interrupt test done");
      for (i = 0; i < 4; i++) begin
         p = $random(seed);
         apb(1'b1, PTR0_OFS, (p & 32'h7fff) | 32'h8000);
         apb(1'b1, PTR1_OFS, p & 32'h7fff);
         ind(1'b0, 1'b0, 3, 1'b0);
         chk("pm_byte", ind_rd, p[7:0] ^ {2{p[11:8]}});
         ind(1'b1, 1'b0, 2, 1'b0);
         chk("dm_byte", ind_rd, p[7:0] ^ {1'b0, p[14:8]});
         ind(1'b0, 1'b1, 2, 1'b0);
         ind(1'b1, 1'b1, 2, 1'b1);
         chk("rd_hold", ind_rd, p[7:0] ^ {1'b0, p[14:8]});
      end
      for (i = 0; i < 64; i++) begin
         insn <= 6'(i);
         @(posedge clk);
         chk("illegal", ill, i >= NUM_INSN);
      end
      $display("indirect and decode test done");
      complete_run();
   end

   // the whole run needs well under a thousand cycles
   initial begin
      #(40 * 5000);
      err_count++;
      complete_run();
   end
endmodule : pcm_core_addr_tb
